// ===== rtl/sdr_defs.vh
`ifndef SDR_DEFS_VH
`define SDR_DEFS_VH
// register offsets (system I/O low nibble and local index share them)
`define SDR_OFS_ID0      4'h0
`define SDR_OFS_ID1      4'h1
`define SDR_OFS_ID2      4'h2
`define SDR_OFS_ID3      4'h3
`define SDR_OFS_CFG      4'h8
`define SDR_OFS_ICTL     4'h9
`define SDR_OFS_DBMASK   4'he
`define SDR_OFS_DBSTAT   4'hf
// reset values
`define SDR_RST_MASK     8'h00
`define SDR_RST_ICTL     1'b0
`define SDR_RST_CFGLO    4'h0
`define SDR_RST_ID0      8'h70
// field positions
`define SDR_ICTL_EN      0
`define SDR_ICTL_PEND    1
`define SDR_CFG_SYSEDGE  3
`define SDR_CFG_BRDPOL   2
`define SDR_CFG_PRE_HI   1
`define SDR_CFG_PRE_LO   0
// preempt release delays in bus clocks
`define SDR_PRE_CODE0    7'd3
`define SDR_PRE_CODE1    7'd32
`define SDR_PRE_CODE2    7'd64
`define SDR_PRE_CODE3    7'd0
`endif

// ===== rtl/sdr_irq_out.v
`timescale 1ns/1ns
`include "sdr_defs.vh"
// system interrupt pin shaping: edge high or level low
module sdr_irq_out (
  input  wire i_clock,    // clock
  input  wire i_reset,    // sync reset
  input  wire i_request,  // internal request, active high
  input  wire i_edge_sel, // 1 edge active high, 0 level active low
  output reg  o_pin       // registered pin value
);
  // level mode drives inverted request; edge mode drives high request
  always @(posedge i_clock)
  begin
    if (i_reset)
      o_pin <= 1'b1;
    else if (i_edge_sel)
      o_pin <= i_request;
    else
      o_pin <= ~i_request;
  end
endmodule

// ===== rtl/sdr_shared_regs.v
// Overview of operation
// - doorbell enable bits gate matching status bits
// - mask written by system, read locally, resets zero
// - control bit0 enables system interrupt output
// - control bit1 shows any enabled pending doorbell
// - control read-only locally, resets to zero
// - config bit3: edge high or level low
// - config bit2 sets board interrupt polarity
// - config bits1:0 pick preempt hold delay
// - config 7:4 fixed revision; reset low nibble
// - config written locally, read-only from system
// - local loads id bytes; system reads them
// - id byte0 resets to delay pattern 0111
// - external id scheme hides internal id from system reads
// - id byte fields: maker chars, product digits
// - id contents affect no internal behaviour
// - local write sets status, system write clears
`timescale 1ns/1ns
`include "sdr_defs.vh"
module sdr_shared_regs #(
  parameter [3:0] HW_REVISION = 4'h1 // arbitrary revision value
) (
  input  wire       i_clock,          // 25 MHz clock
  input  wire       i_reset,          // sync reset, active high
  input  wire       i_sys_wr,         // system bus write strobe
  input  wire       i_sys_rd,         // system bus read strobe
  input  wire [3:0] i_sys_addr,       // system I/O low address nibble
  input  wire [7:0] i_sys_wdata,      // system write data
  output reg  [7:0] o_sys_rdata,      // system read data
  output reg        o_sys_rd_valid,   // system read data valid
  input  wire       i_loc_wr,         // local write strobe
  input  wire       i_loc_rd,         // local read strobe
  input  wire [3:0] i_loc_index,      // local register index
  input  wire [7:0] i_loc_wdata,      // local write data
  output reg  [7:0] o_loc_rdata,      // local read data
  output reg        o_loc_rd_valid,   // local read data valid
  input  wire       i_ext_id_sel,     // pin: external id scheme chosen
  input  wire       i_board_irq_req,  // board interrupt request, high
  output wire       o_system_interrupt_out, // shaped system interrupt
  output reg        o_board_interrupt_out,  // polarity-set board irq
  output reg  [6:0] o_preempt_delay   // bus clocks to hold on preempt
);
  reg  [7:0] doorbell_mask;
  reg  [7:0] doorbell_status;
  reg        sys_irq_enable;
  reg  [3:0] config_low;
  reg  [7:0] board_id [0:3];
  wire       ext_id_sync;
  wire [7:0] enabled_pending;
  wire       any_pending;
  wire [7:0] ictl_value;
  wire [7:0] config_value;
  wire       sys_id_hit;
  wire       sys_wr_mask;
  wire       sys_wr_ictl;
  wire       sys_wr_status;
  wire       loc_wr_cfg;
  wire       loc_wr_status;
  reg  [7:0] next_sys_rdata;
  reg  [7:0] next_loc_rdata;
  reg  [6:0] next_preempt;
  reg        board_req_q;
  reg        next_board_irq;
  wire       loc_wr_id;
  wire [7:0] next_doorbell_status;
  reg  [7:0] sys_id_byte;
  // id field view of the four id bytes
  wire [4:0] maker_char_one;
  wire [4:0] maker_char_two;
  wire [4:0] maker_char_three;
  wire [3:0] product_digit_one;
  wire [3:0] product_digit_two;
  wire [3:0] product_digit_three;
  wire [3:0] product_revision_digit;
  wire [7:0] id_image0;
  wire [7:0] id_image1;
  wire [7:0] id_image2;
  wire [7:0] id_image3;

  // strap pin crosses into the clock domain first
  sdr_sync #(
    .WIDTH (1)
  ) u_ext_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async (i_ext_id_sel),
    .o_sync  (ext_id_sync)
  );

  // any enabled pending doorbell
  assign any_pending     = |enabled_pending;
  // control register image with reserved bits zero
  assign ictl_value = {6'b00_0000, any_pending, sys_irq_enable};
  assign config_value = {HW_REVISION, config_low};

  // system side write decodes
  assign sys_wr_mask   = i_sys_wr && (i_sys_addr == `SDR_OFS_DBMASK);
  assign sys_wr_ictl   = i_sys_wr && (i_sys_addr == `SDR_OFS_ICTL);
  assign sys_wr_status = i_sys_wr && (i_sys_addr == `SDR_OFS_DBSTAT);
  // system id reads vanish while the external id scheme is strapped
  assign sys_id_hit    = (i_sys_addr[3:2] == 2'b00) && !ext_id_sync;

  // local side write decodes
  assign loc_wr_cfg    = i_loc_wr && (i_loc_index == `SDR_OFS_CFG);
  assign loc_wr_status = i_loc_wr && (i_loc_index == `SDR_OFS_DBSTAT);
  assign loc_wr_id     = i_loc_wr && (i_loc_index[3:2] == 2'b00);

  // doorbell enable mask: system writes only
  always @(posedge i_clock)
  begin
    if (i_reset)
      doorbell_mask <= `SDR_RST_MASK;
    else if (sys_wr_mask)
      doorbell_mask <= i_sys_wdata;
  end

  // doorbell bits: gate by mask; local set, system clear, set wins
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1)
    begin : g_bell
      // mask bit b gates status bit b
      assign enabled_pending[b] = doorbell_status[b] & doorbell_mask[b];
      assign next_doorbell_status[b] =
        (loc_wr_status && i_loc_wdata[b]) ? 1'b1 :
        (sys_wr_status && i_sys_wdata[b]) ? 1'b0 :
        doorbell_status[b];
    end
  endgenerate

  // doorbell status register, clear on reset
  always @(posedge i_clock)
  begin
    if (i_reset)
      doorbell_status <= 8'h00;
    else
      doorbell_status <= next_doorbell_status;
  end

  // interrupt control enable bit: system writes only
  always @(posedge i_clock)
  begin
    if (i_reset)
      sys_irq_enable <= `SDR_RST_ICTL;
    else if (sys_wr_ictl)
      sys_irq_enable <= i_sys_wdata[`SDR_ICTL_EN];
  end

  // configuration low nibble: local writes only
  always @(posedge i_clock)
  begin
    if (i_reset)
      config_low <= `SDR_RST_CFGLO;
    else if (loc_wr_cfg)
      config_low <= i_loc_wdata[3:0];
  end

  // id bytes: local loads, byte0 reset to delay pattern
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_id
      always @(posedge i_clock)
      begin
        if (i_reset && (g == 0))
          board_id[g] <= `SDR_RST_ID0;
        else if (loc_wr_id && (i_loc_index[1:0] == g))
          board_id[g] <= i_loc_wdata;
      end
    end
  endgenerate

  // id bytes split into maker characters and product digits
  assign maker_char_one         = board_id[0][6:2];
  assign maker_char_two         = {board_id[0][1:0], board_id[1][7:5]};
  assign maker_char_three       = board_id[1][4:0];
  assign product_digit_one      = board_id[2][7:4];
  assign product_digit_two      = board_id[2][3:0];
  assign product_digit_three    = board_id[3][7:4];
  assign product_revision_digit = board_id[3][3:0];

  // system image of the id bytes, reserved bit 7 kept as loaded
  assign id_image0 = {board_id[0][7], maker_char_one, maker_char_two[4:3]};
  assign id_image1 = {maker_char_two[2:0], maker_char_three};
  assign id_image2 = {product_digit_one, product_digit_two};
  assign id_image3 = {product_digit_three, product_revision_digit};

  // id byte picked by the low address bits; fields steer nothing else
  always @*
  begin
    sys_id_byte = 8'h00;
    case (i_sys_addr[1:0])
      2'b00:   sys_id_byte = id_image0;
      2'b01:   sys_id_byte = id_image1;
      2'b10:   sys_id_byte = id_image2;
      default: sys_id_byte = id_image3;
    endcase
  end

  // system read mux
  always @*
  begin
    next_sys_rdata = 8'h00;
    case (i_sys_addr)
      `SDR_OFS_ID0, `SDR_OFS_ID1, `SDR_OFS_ID2, `SDR_OFS_ID3:
        next_sys_rdata = sys_id_hit ? sys_id_byte : 8'h00;
      `SDR_OFS_CFG:    next_sys_rdata = config_value;
      `SDR_OFS_ICTL:   next_sys_rdata = ictl_value;
      `SDR_OFS_DBMASK: next_sys_rdata = doorbell_mask;
      `SDR_OFS_DBSTAT: next_sys_rdata = doorbell_status;
      default:         next_sys_rdata = 8'h00;
    endcase
  end

  // local read mux
  always @*
  begin
    next_loc_rdata = 8'h00;
    case (i_loc_index)
      `SDR_OFS_ID0, `SDR_OFS_ID1, `SDR_OFS_ID2, `SDR_OFS_ID3:
        next_loc_rdata = board_id[i_loc_index[1:0]];
      `SDR_OFS_CFG:    next_loc_rdata = config_value;
      `SDR_OFS_ICTL:   next_loc_rdata = ictl_value;
      `SDR_OFS_DBMASK: next_loc_rdata = doorbell_mask;
      `SDR_OFS_DBSTAT: next_loc_rdata = doorbell_status;
      default:         next_loc_rdata = 8'h00;
    endcase
  end

  // preempt hold delay decode; reserved code gives zero
  always @*
  begin
    case (config_low[`SDR_CFG_PRE_HI:`SDR_CFG_PRE_LO])
      2'b00:   next_preempt = `SDR_PRE_CODE0;
      2'b01:   next_preempt = `SDR_PRE_CODE1;
      2'b10:   next_preempt = `SDR_PRE_CODE2;
      default: next_preempt = `SDR_PRE_CODE3;
    endcase
  end

  // board interrupt level: active high when bit2 set, else active low
  always @*
  begin
    if (config_low[`SDR_CFG_BRDPOL])
      next_board_irq = board_req_q;
    else
      next_board_irq = ~board_req_q;
  end

  // system read answer: data held until the next read
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_sys_rdata    <= 8'h00;
      o_sys_rd_valid <= 1'b0;
    end
    else
    begin
      o_sys_rd_valid <= i_sys_rd;
      if (i_sys_rd)
        o_sys_rdata <= next_sys_rdata;
    end
  end

  // local read answer: data held until the next read
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_loc_rdata    <= 8'h00;
      o_loc_rd_valid <= 1'b0;
    end
    else
    begin
      o_loc_rd_valid <= i_loc_rd;
      if (i_loc_rd)
        o_loc_rdata <= next_loc_rdata;
    end
  end

  // preempt delay and board interrupt registered to the pins
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_preempt_delay       <= `SDR_PRE_CODE0;
      board_req_q           <= 1'b0;
      o_board_interrupt_out <= 1'b1;
    end
    else
    begin
      o_preempt_delay       <= next_preempt;
      board_req_q           <= i_board_irq_req;
      o_board_interrupt_out <= next_board_irq;
    end
  end

  // system interrupt: enable and pending, shaped by config bit3
  sdr_irq_out u_irq_out (
    .i_clock    (i_clock),
    .i_reset    (i_reset),
    .i_request  (sys_irq_enable & any_pending),
    .i_edge_sel (config_low[`SDR_CFG_SYSEDGE]),
    .o_pin      (o_system_interrupt_out)
  );
  // id contents feed only the read paths above
endmodule

// ===== rtl/sdr_sync.v
`timescale 1ns/1ns
// two-flop synchroniser for external levels
module sdr_sync #(
  parameter WIDTH = 1
) (
  input  wire             i_clock, // clock
  input  wire             i_reset, // sync reset
  input  wire [WIDTH-1:0] i_async, // async level
  output reg  [WIDTH-1:0] o_sync   // synchronised level
);
  reg [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      stage1 <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

// ===== tb/sdr_far_model.sv
`timescale 1ns/1ns
// far-side pins: board request and id strap, moved off the edge
module sdr_far_model (
  input  wire i_clock,                // clock
  input  wire i_irq_level,            // wanted board request
  input  wire i_ext_level,            // wanted id strap
  output reg  o_board_irq_req = 1'b0, // board request pin
  output reg  o_ext_id_sel    = 1'b0  // external id strap pin
);
  // pins change at the falling edge only
  always @(negedge i_clock)
    {o_board_irq_req, o_ext_id_sel} <= {i_irq_level, i_ext_level};
endmodule

// ===== tb/sdr_shared_regs_asserts.sv
`timescale 1ns/1ns
// read answers, reserved bits and preempt output
module sdr_chk #(
  parameter [3:0] HW_REVISION = 4'h1 // arbitrary revision value
) (
  input wire       i_clock,        // clock
  input wire       i_reset,        // sync reset
  input wire       i_sys_rd,       // system read
  input wire [3:0] i_sys_addr,     // system address
  input wire [7:0] o_sys_rdata,    // system data
  input wire       o_sys_rd_valid, // system valid
  input wire       i_loc_rd,       // local read
  input wire [3:0] i_loc_index,    // local index
  input wire [7:0] o_loc_rdata,    // local data
  input wire       o_loc_rd_valid, // local valid
  input wire [6:0] o_preempt_delay // preempt hold
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // every read is answered one cycle on; system valid only follows a system read
  a_sys_rd_valid: assert property (i_sys_rd |=> o_sys_rd_valid)
    else $error("system read not answered");
  a_sys_no_spur: assert property (!i_sys_rd |=> !o_sys_rd_valid)
    else $error("system valid without read");
  a_loc_rd_valid: assert property (i_loc_rd |=> o_loc_rd_valid)
    else $error("local read not answered");
  // reserved and fixed fields
  a_ctl_sys_zero: assert property (i_sys_rd && i_sys_addr == 4'h9
    |=> o_sys_rdata[7:2] == 6'h00) else $error("control high bits set");
  a_ctl_loc_zero: assert property (i_loc_rd && i_loc_index == 4'h9
    |=> o_loc_rdata[7:2] == 6'h00) else $error("local control bad");
  a_cfg_rev_fixed: assert property (i_sys_rd && i_sys_addr == 4'h8
    |=> o_sys_rdata[7:4] == HW_REVISION) else $error("revision wrong");
  // preempt hold takes only the coded values
  a_preempt_codes: assert property (o_preempt_delay inside
    {7'd3, 7'd32, 7'd64, 7'd0}) else $error("preempt value bad");
  a_rst_preempt: assert property ($fell(i_reset) |->
    o_preempt_delay == 7'd3) else $error("preempt not reset");
endmodule
bind sdr_shared_regs sdr_chk #(.HW_REVISION(HW_REVISION)) i_sdr_chk (
  .i_clock(i_clock), .i_reset(i_reset), .i_sys_rd(i_sys_rd),
  .i_sys_addr(i_sys_addr), .o_sys_rdata(o_sys_rdata),
  .o_sys_rd_valid(o_sys_rd_valid), .i_loc_rd(i_loc_rd),
  .i_loc_index(i_loc_index), .o_loc_rdata(o_loc_rdata),
  .o_loc_rd_valid(o_loc_rd_valid), .o_preempt_delay(o_preempt_delay));

// ===== tb/sdr_shared_regs_tb_top.sv
`timescale 1ns/1ns
module sdr_shared_regs_tb_top;
  localparam [3:0] REV = 4'h1; // arbitrary revision value
  reg        i_clock = 1'b0, i_reset = 1'b1, irq_lvl = 1'b0, ext_lvl = 1'b0;
  reg        i_sys_wr = 1'b0, i_sys_rd = 1'b0, i_loc_wr = 1'b0;
  reg        i_loc_rd = 1'b0;
  reg  [3:0] i_sys_addr = 4'h0, i_loc_index = 4'h0;
  reg  [7:0] i_sys_wdata = 8'h00, i_loc_wdata = 8'h00;
  wire [7:0] sys_rdata, loc_rdata;
  wire       sys_vld, loc_vld, sys_irq, brd_irq, brd_req, ext_sel;
  wire [6:0] pre;
  reg  [7:0] exp_pre;
  localparam [1:0] PRE = 2'd0, BRD = 2'd1, SYS = 2'd2; // pin selectors
  integer    n_fail = 0, checks_done = 0, cyc = 0, k, t;
  sdr_shared_regs #(.HW_REVISION(REV)) i_sdr_shared_regs (
    .i_clock(i_clock), .i_reset(i_reset), .i_sys_wr(i_sys_wr),
    .i_sys_rd(i_sys_rd), .i_sys_addr(i_sys_addr), .i_sys_wdata(i_sys_wdata),
    .o_sys_rdata(sys_rdata), .o_sys_rd_valid(sys_vld), .i_loc_wr(i_loc_wr),
    .i_loc_rd(i_loc_rd), .i_loc_index(i_loc_index),
    .i_loc_wdata(i_loc_wdata), .o_loc_rdata(loc_rdata),
    .o_loc_rd_valid(loc_vld), .i_ext_id_sel(ext_sel),
    .i_board_irq_req(brd_req), .o_system_interrupt_out(sys_irq),
    .o_board_interrupt_out(brd_irq), .o_preempt_delay(pre));
  sdr_far_model i_sdr_far_model (.i_clock(i_clock), .i_irq_level(irq_lvl),
    .i_ext_level(ext_lvl), .o_board_irq_req(brd_req),
    .o_ext_id_sel(ext_sel));
  // 25 MHz clock and cycle ceiling
  always #20 i_clock = ~i_clock;
  always @(posedge i_clock)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // one access: s=1 system side, w=1 write; a read compares with d
  task acc(input s, input w, input [3:0] a, input [7:0] d);
  begin
    @(negedge i_clock);
    if (s)
      {i_sys_wr, i_sys_rd, i_sys_addr, i_sys_wdata} = {w, !w, a, d};
    else
      {i_loc_wr, i_loc_rd, i_loc_index, i_loc_wdata} = {w, !w, a, d};
    @(negedge i_clock);
    {i_sys_wr, i_sys_rd, i_loc_wr, i_loc_rd} = 4'h0;
    for (k = 0; k < 3 && !w && (s ? sys_vld : loc_vld) !== 1'b1; k = k + 1)
      @(negedge i_clock);
    if (!w)
      chk(s ? sys_rdata : loc_rdata, d);
  end
  endtask
  // let registered outputs settle, then sample and compare a pin
  task pin(input [1:0] sel, input [7:0] exp);
  begin
    repeat (3) @(negedge i_clock);
    case (sel)
      PRE:     chk({1'b0, pre}, exp);
      BRD:     chk({7'h00, brd_irq}, exp);
      default: chk({7'h00, sys_irq}, exp);
    endcase
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20) @(negedge i_clock);
    i_reset = 1'b0;
    // reset values, then writes from the wrong side are ignored
    acc(1, 0, 4'he, 8'h00);
    acc(0, 0, 4'h9, 8'h00);
    acc(1, 0, 4'h0, 8'h70);
    acc(1, 0, 4'h8, {REV, 4'h0});
    acc(0, 1, 4'he, 8'hff);
    acc(1, 1, 4'h9, 8'hff);
    acc(0, 1, 4'h9, 8'h00);
    acc(0, 0, 4'he, 8'h00);
    acc(1, 0, 4'h9, 8'h01);
    acc(0, 0, 4'h9, 8'h01);
    acc(1, 0, 4'h4, 8'h00);
    $display("test 1 finished");
    // every preempt code, then a refused system write
    for (t = 0; t < 4; t = t + 1)
    begin
      acc(0, 1, 4'h8, t[7:0]);
      exp_pre = (t == 0) ? 8'h03 : (t == 1) ? 8'h20 : (t == 2) ? 8'h40 : 8'h00;
      pin(PRE, exp_pre);
    end
    acc(1, 1, 4'h8, 8'h00);
    acc(1, 0, 4'h8, {REV, 4'h3});
    acc(0, 1, 4'h8, 8'h04);
    irq_lvl = 1'b1;
    pin(BRD, 8'h01);
    acc(0, 1, 4'h8, 8'h00);
    pin(BRD, 8'h00);
    $display("test 2 finished");
    // doorbell set, mask, clear, enable and both pin modes
    acc(1, 1, 4'he, 8'h01);
    acc(0, 1, 4'hf, 8'h03);
    acc(1, 0, 4'hf, 8'h03);
    acc(1, 0, 4'h9, 8'h03);
    pin(SYS, 8'h00);
    acc(1, 1, 4'hf, 8'h01);
    acc(1, 0, 4'h9, 8'h01);
    pin(SYS, 8'h01);
    acc(0, 1, 4'hf, 8'h01);
    acc(1, 1, 4'h9, 8'h00);
    acc(1, 0, 4'h9, 8'h02);
    pin(SYS, 8'h01);
    acc(0, 1, 4'h8, 8'h08);
    pin(SYS, 8'h00);
    acc(1, 1, 4'h9, 8'h01);
    pin(SYS, 8'h01);
    $display("test 3 finished");
    // id bytes loaded locally, byte 0 last, then external scheme
    acc(0, 1, 4'h1, 8'haa);
    acc(0, 1, 4'h0, 8'h12);
    acc(1, 1, 4'h0, 8'hff);
    acc(1, 0, 4'h0, 8'h12);
    acc(1, 0, 4'h1, 8'haa);
    pin(PRE, 8'h03);
    ext_lvl = 1'b1;
    repeat (4) @(negedge i_clock);
    acc(1, 0, 4'h0, 8'h00);
    $display("test 4 finished");
    // mid-run reset clears mask, control and config, restores board_id_byte0
    @(negedge i_clock);
    i_reset = 1'b1;
    repeat (2) @(negedge i_clock);
    i_reset = 1'b0;
    acc(1, 0, 4'he, 8'h00);
    acc(1, 0, 4'h8, {REV, 4'h0});
    acc(0, 0, 4'h0, 8'h70);
    acc(1, 0, 4'h9, 8'h00);
    pin(SYS, 8'h01);
    pin(BRD, 8'h00);
    $display("test 5 finished");
    print_verdict;
  end
endmodule
